// file: design/timer_regs.svh
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH
// ==========================================================
// clock rates in Hz, used by the fractional tick dividers
`define PCLK_HZ      26'd40000000
`define RAT_HZ       26'd4000000
`define WDT_HZ       26'd1500000
`define AUXF_HZ      26'd24000000
`define AUXM_HZ      26'd2000000
// ==========================================================
// register byte offsets
`define A_CTRL       12'h000
`define A_RTC_INC    12'h004
`define A_RTC_FRAC   12'h008
`define A_RTC_SEC    12'h00C
`define A_RTC_TOP    12'h010
`define A_RTC_CAP    12'h020
`define A_RTC_CAPE   12'h02C
`define A_GPT_LO     12'h040
`define A_GPT_HI     12'h0C0
`define A_AUX_HI     12'h0E0
`define A_AX2_CTRL   12'h0E0
`define A_AX2_PER    12'h0E4
`define A_AX2_CNT    12'h0E8
`define A_AX2_CH     12'h0F0
`define A_AX2_CHE    12'h100
`define A_RAT        12'h100
`define A_RAT_STAT   12'h104
`define A_WDT_LOAD   12'h110
`define A_WDT_CTRL   12'h114
`define A_WDT_CLR    12'h118
`define A_WDT_CNT    12'h11C
// word index inside a 16-byte timer slot
`define S_CTRL       2'd0
`define S_LOAD       2'd1
`define S_MATCH      2'd2
`define S_CNT        2'd3
// ==========================================================
// field positions
`define C_RTC_EN     0
`define C_RTC_DBGRUN 1
`define G_EN         0
`define G_MODE       3:1
`define G_JOIN       4
`define X_EN         0
`define X_ONE        1
`define X_EDGE       2
`define X_SRC        4:3
`define X_PRE        8:5
`define X2_EN        0
`define X2_SEL       2:1
`define X2_ONE       3
`define X2_32K       2'd2
`define X2_24M       2'd0
`define CH_VAL       15:0
`define CH_EN        16
`define CH_CAP       17
`define CH_ONE       18
`define W_EN         0
`define W_IRQ        1
// positions in the synchronised input vector
`define I_LF         0
`define I_DBG        1
`define I_RON        2
`define I_XOK        3
`define I_PWR        4
`define I_GPT        6
`define I_AUX        14
`define I_CAP2       18
`define I_RCAP       22
// ==========================================================
// reset values
`define RST_CTRL     2'b01
`define RST_RTC_INC  32'h0002_0000
`define RST_WDT_LOAD 32'h0000_FFFF
`endif

// file: design/timer_pkg.sv
package timer_pkg;
    // ======================================================
    // counting modes of one general timer half
    typedef enum logic [2:0] {
        G_ONESHOT   = 3'b000,
        G_PERIODIC  = 3'b001,
        G_PWM       = 3'b010,
        G_EDGE_TIME = 3'b011,
        G_EDGE_CNT  = 3'b100
    } gpt_mode_t;

    typedef enum logic [1:0] {
        PM_ACTIVE   = 2'b00,
        PM_IDLE     = 2'b01,
        PM_STANDBY  = 2'b10,
        PM_SHUTDOWN = 2'b11
    } pwr_mode_t;

    // ======================================================
    // complete register state of the timer block
    typedef struct packed {
        logic [24:0]       s1, s2, s3;
        logic [1:0]        ctrl;
        logic [69:0]       rtc;
        logic [31:0]       rtc_inc;
        logic [2:0][31:0]  rtc_cap;
        logic [25:0]       rat_acc;
        logic [31:0]       rat;
        logic [7:0][4:0]   g_ctrl;
        logic [7:0][15:0]  g_load, g_match, g_cnt;
        logic [7:0]        g_out, g_tmo;
        logic [14:0]       pre;
        logic [1:0][8:0]   a_ctrl;
        logic [1:0][15:0]  a_tgt, a_cnt;
        logic [1:0]        a_evt;
        logic [3:0]        x_ctrl;
        logic [15:0]       x_per, x_cnt;
        logic [25:0]       x_acc;
        logic [3:0][18:0]  x_ch;
        logic [3:0]        x_evt, x_pwm;
        logic [25:0]       w_acc;
        logic [31:0]       w_load, w_cnt;
        logic              w_en, w_irq, w_rst;
        logic              pready, pslverr;
        logic [31:0]       prdata;
    } state_t;
endpackage

// file: design/timer_subsystem.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "timer_regs.svh"
// Behaviour
// - 70-bit three-channel counter on slow clock
// - counter runs in all modes but shutdown
// - tick increment is software adjustable
// - sensor side reads time; capture channels
// - counter halts under debug halt by default
// - four units, one 32 or two 16
// - oneshot, periodic, pwm, edge time, edge count
// - timer inputs and outputs on event fabric
// - general timers run only active or idle
// - aux timers 0,1 16-bit, 2^N prescaler
// - aux 0,1 clock or edge tick, oneshot/periodic
// - aux timer 2 at 24M, 2M, 32k
// - aux timer 2 four capture/compare channels
// - aux timer 2 events and pwm outputs
// - radio counter 32-bit at 4 MHz
// - radio counter resynced from slow counter
// - watchdog at 1.5 MHz, enable is sticky
// - watchdog gives interrupt then reset
// - watchdog frozen in standby and debug halt
module timer_subsystem
    import timer_pkg::*;
(
    input  logic        pclk,
    input  logic        presetn,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [11:0] paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic        low_freq_sys_clock,
    input  logic        dbg_halt,
    input  logic [1:0]  pwr_mode,
    input  logic        radio_on,
    input  logic        xosc_hf_ok,
    input  logic [7:0]  gpt_evt_in,
    input  logic [3:0]  aux_tick_in,
    input  logic [3:0]  aux2_cap_in,
    input  logic [2:0]  rtc_cap_in,
    output logic [31:0] rtc_time,
    output logic [31:0] rat_time,
    output logic [7:0]  gpt_out,
    output logic [7:0]  gpt_tmo,
    output logic [1:0]  aux_evt,
    output logic [3:0]  aux2_evt,
    output logic [3:0]  aux2_pwm,
    output logic        wdt_irq,
    output logic        wdt_rst
);
    state_t      state_q, state_d;
    logic [24:0] raw, rise, tog;
    logic [89:0] prod;
    logic [33:0] r;
    logic [31:0] c32, l32, m32, rdv;
    logic [26:0] f1, f2, f3;
    logic [8:0]  actl;
    logic [18:0] ch;
    logic        jn, ev, tk, xtk, hit, run_on, gpt_run, dbg, wr, clr;
    gpt_mode_t   md;
    pwr_mode_t   pm;

    // ======================================================
    // helpers
    // one step of a down counter; returns {timeout, pwm, next}
    function automatic logic [33:0] gstep(input logic [31:0] cnt,
        input logic [31:0] ld, input logic [31:0] mt,
        input gpt_mode_t mode, input logic ed);
        logic [33:0] o;
        o = {2'b00, cnt - 32'h1};
        case (mode)
            G_EDGE_CNT: begin
                o[31:0] = ed ? ((cnt == mt) ? ld : cnt - 32'h1) : cnt;
                o[33] = ed && (cnt == mt);
            end
            default: begin
                if (cnt == 32'h0) begin
                    o[31:0] = ld;
                    o[33] = 1'b1;
                end
            end
        endcase
        o[32] = (mode == G_PWM) && (cnt <= mt);
        return o;
    endfunction

    // fractional divider: rate = inc / pclk, returns {tick, acc}
    function automatic logic [26:0] fstep(input logic [25:0] acc,
        input logic [25:0] inc);
        logic [26:0] s;
        s = {1'b0, acc} + {1'b0, inc};
        if (s >= {1'b0, `PCLK_HZ})
            return {1'b1, 26'(s - {1'b0, `PCLK_HZ})};
        return {1'b0, s[25:0]};
    endfunction

    // prescaler hit every 2^n cycles
    function automatic logic phit(input logic [14:0] pre,
        input logic [3:0] n);
        logic [14:0] m;
        m = 15'((16'h1 << n) - 16'h1);
        return (pre & m) == m;
    endfunction

    // ======================================================
    // all non-bus input pins pass two flops; edges look at stages 2 and 3
    assign raw  = {rtc_cap_in, aux2_cap_in, aux_tick_in, gpt_evt_in,
                   pwr_mode, xosc_hf_ok, radio_on, dbg_halt,
                   low_freq_sys_clock};
    assign rise = state_q.s2 & ~state_q.s3;
    assign tog  = state_q.s2 ^ state_q.s3;
    assign prod = state_q.rtc[63:0] * `RAT_HZ;

    // ======================================================
    // next-state logic
    always_comb begin
        state_d = state_q;
        state_d.s1 = raw;
        state_d.s2 = state_q.s1;
        state_d.s3 = state_q.s2;
        pm = pwr_mode_t'(state_q.s2[`I_PWR +: 2]);
        dbg = state_q.s2[`I_DBG];
        run_on = pm != PM_SHUTDOWN;
        gpt_run = (pm == PM_ACTIVE) || (pm == PM_IDLE);

        // slow counter: 32-bit fraction below 38-bit seconds
        if (rise[`I_LF] && state_q.ctrl[`C_RTC_EN] && run_on &&
            !(dbg && !state_q.ctrl[`C_RTC_DBGRUN]))
            state_d.rtc = state_q.rtc + 70'(state_q.rtc_inc);
        for (int c = 0; c < 3; c++) begin
            if (rise[`I_RCAP + c])
                state_d.rtc_cap[c] = state_q.rtc[47:16];
        end

        // radio counter; both radio edges reload it from the slow time
        f1 = fstep(state_q.rat_acc, `RAT_HZ);
        state_d.rat_acc = f1[25:0];
        if (tog[`I_RON])
            state_d.rat = prod[63:32];
        else if (state_q.s2[`I_RON] && f1[26])
            state_d.rat = state_q.rat + 32'h1;

        // general timers: an even half with join set drives both
        state_d.g_tmo = '0;
        for (int h = 0; h < 8; h++) begin
            jn = state_q.g_ctrl[h & 6][`G_JOIN];
            md = gpt_mode_t'(state_q.g_ctrl[h][`G_MODE]);
            c32 = {jn ? state_q.g_cnt[h | 1] : 16'h0, state_q.g_cnt[h]};
            l32 = {jn ? state_q.g_load[h | 1] : 16'h0,
                   state_q.g_load[h]};
            m32 = {jn ? state_q.g_match[h | 1] : 16'h0,
                   state_q.g_match[h]};
            ev = rise[`I_GPT + h];
            r = gstep(c32, l32, m32, md, ev);
            if (!(jn && (h % 2 == 1))) begin
                state_d.g_out[h] = r[32];
                if (jn)
                    state_d.g_out[h | 1] = r[32];
                if (gpt_run && state_q.g_ctrl[h][`G_EN]) begin
                    state_d.g_cnt[h] = r[15:0];
                    if (jn)
                        state_d.g_cnt[h | 1] = r[31:16];
                    state_d.g_tmo[h] = r[33];
                    if (r[33] && md == G_ONESHOT)
                        state_d.g_ctrl[h][`G_EN] = 1'b0;
                    if (ev && md == G_EDGE_TIME) begin
                        state_d.g_match[h] = c32[15:0];
                        if (jn)
                            state_d.g_match[h | 1] = c32[31:16];
                    end
                end
            end
        end

        // aux timers 0 and 1 count up to their target
        state_d.pre = state_q.pre + 15'h1;
        state_d.a_evt = '0;
        for (int t = 0; t < 2; t++) begin
            actl = state_q.a_ctrl[t];
            tk = actl[`X_EDGE] ? tog[`I_AUX + actl[`X_SRC]]
                               : phit(state_q.pre, actl[`X_PRE]);
            if (run_on && actl[`X_EN] && tk) begin
                if (state_q.a_cnt[t] == state_q.a_tgt[t]) begin
                    state_d.a_cnt[t] = '0;
                    state_d.a_evt[t] = 1'b1;
                    if (actl[`X_ONE])
                        state_d.a_ctrl[t][`X_EN] = 1'b0;
                end else begin
                    state_d.a_cnt[t] = state_q.a_cnt[t] + 16'h1;
                end
            end
        end

        // aux timer 2: 24 MHz is a fractional rate, jitter of a cycle
        f2 = fstep(state_q.x_acc,
                   state_q.x_ctrl[`X2_SEL] == `X2_24M ? `AUXF_HZ
                                                      : `AUXM_HZ);
        state_d.x_acc = f2[25:0];
        xtk = (state_q.x_ctrl[`X2_SEL] == `X2_32K) ? rise[`I_LF]
                                                   : f2[26];
        state_d.x_evt = '0;
        ch = '0;
        if (run_on && state_q.x_ctrl[`X2_EN]) begin
            if (xtk) begin
                if (state_q.x_cnt == state_q.x_per) begin
                    state_d.x_cnt = '0;
                    if (state_q.x_ctrl[`X2_ONE])
                        state_d.x_ctrl[`X2_EN] = 1'b0;
                end else begin
                    state_d.x_cnt = state_q.x_cnt + 16'h1;
                end
            end
            for (int c = 0; c < 4; c++) begin
                ch = state_q.x_ch[c];
                hit = ch[`CH_CAP] ? rise[`I_CAP2 + c]
                                  : xtk && state_q.x_cnt == ch[`CH_VAL];
                if (ch[`CH_EN]) begin
                    if (hit) begin
                        state_d.x_evt[c] = 1'b1;
                        if (ch[`CH_CAP])
                            state_d.x_ch[c][`CH_VAL] = state_q.x_cnt;
                        if (ch[`CH_ONE])
                            state_d.x_ch[c][`CH_EN] = 1'b0;
                    end
                    state_d.x_pwm[c] = !ch[`CH_CAP] &&
                                       state_q.x_cnt < ch[`CH_VAL];
                end
            end
        end

        // ==================================================
        // bus slave: one wait cycle, data registered on the same edge as pready
        wr = psel && penable && state_q.pready && pwrite;
        clr = 1'b0;
        hit = 1'b1;
        rdv = '0;
        if (paddr == `A_CTRL) begin
            rdv = {30'h0, state_q.ctrl};
            if (wr)
                state_d.ctrl = pwdata[1:0];
        end else if (paddr == `A_RTC_INC) begin
            rdv = state_q.rtc_inc;
            if (wr)
                state_d.rtc_inc = pwdata;
        end else if (paddr == `A_RTC_FRAC) begin
            rdv = state_q.rtc[31:0];
        end else if (paddr == `A_RTC_SEC) begin
            rdv = state_q.rtc[63:32];
        end else if (paddr == `A_RTC_TOP) begin
            rdv = {26'h0, state_q.rtc[69:64]};
        end else if (paddr >= `A_RTC_CAP && paddr < `A_RTC_CAPE) begin
            rdv = state_q.rtc_cap[paddr[3:2]];
        end else if (paddr >= `A_GPT_LO && paddr < `A_GPT_HI) begin
            l32 = 32'(paddr - `A_GPT_LO);
            case (paddr[3:2])
                `S_CTRL:  rdv = {27'h0, state_q.g_ctrl[l32[6:4]]};
                `S_LOAD:  rdv = {16'h0, state_q.g_load[l32[6:4]]};
                `S_MATCH: rdv = {16'h0, state_q.g_match[l32[6:4]]};
                default:  rdv = {16'h0, state_q.g_cnt[l32[6:4]]};
            endcase
            if (wr && paddr[3:2] == `S_CTRL)
                state_d.g_ctrl[l32[6:4]] = pwdata[4:0];
            if (wr && paddr[3:2] == `S_LOAD) begin
                state_d.g_load[l32[6:4]] = pwdata[15:0];
                state_d.g_cnt[l32[6:4]] = pwdata[15:0];
            end
            if (wr && paddr[3:2] == `S_MATCH)
                state_d.g_match[l32[6:4]] = pwdata[15:0];
        end else if (paddr >= `A_GPT_HI && paddr < `A_AUX_HI &&
                     paddr[3:2] != `S_CNT) begin
            case (paddr[3:2])
                `S_CTRL: rdv = {23'h0, state_q.a_ctrl[paddr[4]]};
                `S_LOAD: rdv = {16'h0, state_q.a_tgt[paddr[4]]};
                default: rdv = {16'h0, state_q.a_cnt[paddr[4]]};
            endcase
            if (wr && paddr[3:2] == `S_CTRL) begin
                state_d.a_ctrl[paddr[4]] = pwdata[8:0];
                state_d.a_cnt[paddr[4]] = '0;
            end
            if (wr && paddr[3:2] == `S_LOAD)
                state_d.a_tgt[paddr[4]] = pwdata[15:0];
        end else if (paddr == `A_AX2_CTRL) begin
            rdv = {28'h0, state_q.x_ctrl};
            if (wr) begin
                state_d.x_ctrl = pwdata[3:0];
                state_d.x_cnt = '0;
            end
        end else if (paddr == `A_AX2_PER) begin
            rdv = {16'h0, state_q.x_per};
            if (wr)
                state_d.x_per = pwdata[15:0];
        end else if (paddr == `A_AX2_CNT) begin
            rdv = {16'h0, state_q.x_cnt};
        end else if (paddr >= `A_AX2_CH && paddr < `A_AX2_CHE) begin
            rdv = {13'h0, state_q.x_ch[paddr[3:2]]};
            if (wr)
                state_d.x_ch[paddr[3:2]] = pwdata[18:0];
        end else if (paddr == `A_RAT) begin
            rdv = state_q.rat;
        end else if (paddr == `A_RAT_STAT) begin
            rdv = {30'h0, state_q.s2[`I_XOK], state_q.s2[`I_RON]};
        end else if (paddr == `A_WDT_LOAD) begin
            rdv = state_q.w_load;
            if (wr)
                state_d.w_load = pwdata;
        end else if (paddr == `A_WDT_CTRL) begin
            rdv = {30'h0, state_q.w_irq, state_q.w_en};
            if (wr && pwdata[`W_EN])
                state_d.w_en = 1'b1;
        end else if (paddr == `A_WDT_CLR) begin
            clr = wr;
        end else if (paddr == `A_WDT_CNT) begin
            rdv = state_q.w_cnt;
        end else begin
            hit = 1'b0;
        end
        if (!hit)
            clr = 1'b0;
        state_d.pready = psel && penable && !state_q.pready;
        state_d.pslverr = state_d.pready && !hit;
        if (state_d.pready)
            state_d.prdata = rdv;

        // ==================================================
        // watchdog; a timeout in the service cycle still sets irq
        if (clr) begin
            state_d.w_cnt = state_q.w_load;
            state_d.w_irq = 1'b0;
        end
        f3 = fstep(state_q.w_acc, `WDT_HZ);
        state_d.w_acc = f3[25:0];
        state_d.w_rst = 1'b0;
        if (state_q.w_en && run_on && pm != PM_STANDBY && !dbg &&
            f3[26]) begin
            if (state_q.w_cnt == 32'h0) begin
                state_d.w_cnt = state_q.w_load;
                if (state_q.w_irq && !clr) begin
                    state_d.w_rst = 1'b1;
                    state_d.w_irq = 1'b0;
                end else begin
                    state_d.w_irq = 1'b1;
                end
            end else if (!clr) begin
                state_d.w_cnt = state_q.w_cnt - 32'h1;
            end
        end
    end

    // ======================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
            state_q.ctrl <= `RST_CTRL;
            state_q.rtc_inc <= `RST_RTC_INC;
            state_q.w_load <= `RST_WDT_LOAD;
            state_q.w_cnt <= `RST_WDT_LOAD;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs are flop bits
    assign prdata   = state_q.prdata;
    assign pready   = state_q.pready;
    assign pslverr  = state_q.pslverr;
    assign rtc_time = state_q.rtc[47:16];
    assign rat_time = state_q.rat;
    assign gpt_out  = state_q.g_out;
    assign gpt_tmo  = state_q.g_tmo;
    assign aux_evt  = state_q.a_evt;
    assign aux2_evt = state_q.x_evt;
    assign aux2_pwm = state_q.x_pwm;
    assign wdt_irq  = state_q.w_irq;
    assign wdt_rst  = state_q.w_rst;
endmodule

// file: bench/timer_props.sv
`timescale 1ns/100ps
// ==========================================================
// port-level properties of the timer block
module timer_props (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pready,
    input logic        pslverr,
    input logic        dbg_halt,
    input logic [1:0]  pwr_mode,
    input logic        radio_on,
    input logic [7:0]  gpt_tmo,
    input logic [31:0] rtc_time,
    input logic [31:0] rat_time,
    input logic        wdt_irq,
    input logic        wdt_rst
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // six cycles cover the two sync flops plus a pulse in flight
    a_apb_one_wait: assert property (
        $rose(penable) && psel |-> !pready ##1 pready)
        else $error("bus answer not after one wait state");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("error without ready");
    a_gpt_sleep_quiet: assert property (
        pwr_mode[1] [*6] |-> gpt_tmo == 8'h00)
        else $error("general timer fired in deep mode");
    a_rtc_debug_halt: assert property (
        dbg_halt [*6] |-> $stable(rtc_time))
        else $error("slow counter moved under debug halt");
    a_rtc_shutdown: assert property (
        (pwr_mode == 2'h3) [*6] |-> $stable(rtc_time))
        else $error("slow counter moved in shutdown");
    a_rat_radio_off: assert property (
        !radio_on [*6] |-> $stable(rat_time))
        else $error("radio counter moved with radio off");
    a_wdt_rst_pulse: assert property (
        wdt_rst |=> !wdt_rst)
        else $error("watchdog reset longer than one cycle");
    a_wdt_irq_first: assert property (
        wdt_rst |-> $past(wdt_irq) && !wdt_irq)
        else $error("watchdog reset without prior interrupt");
    a_wdt_debug_freeze: assert property (
        dbg_halt [*6] |-> !$rose(wdt_irq) && !wdt_rst)
        else $error("watchdog fired under debug halt");
endmodule

// file: bench/timer_subsystem_tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench, integer model of counter values
module timer_subsystem_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        lf = 1'b0;
    logic        dbg_halt = 1'b0;
    logic        radio_on = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0]  pwr_mode = 2'h0;
    logic [2:0]  rtc_cap_in = 3'h0;
    logic [31:0] prdata, rtc_time, rat_time, rd;
    logic [7:0]  gpt_out, gpt_tmo;
    logic [3:0]  aux2_evt, aux2_pwm, sel;
    logic [1:0]  aux_evt;
    logic        pready, pslverr, wdt_irq, wdt_rst, er;
    int          errors = 0, tests_run = 0, c, n, m, v, rm;
    logic [11:0] ra [4] = '{12'h000, 12'h004, 12'h110, 12'h11C};
    logic [31:0] rv [4] = '{32'h1, 32'h20000, 32'hFFFF, 32'hFFFF};

    always #12.5 pclk = ~pclk;
    assign sel = {wdt_rst, wdt_irq, aux_evt[0], gpt_tmo[0]};

    // unused event inputs held low, their logic is left untested
    timer_subsystem u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_freq_sys_clock(lf),
        .dbg_halt(dbg_halt), .pwr_mode(pwr_mode),
        .radio_on(radio_on), .xosc_hf_ok(1'b1),
        .gpt_evt_in(8'h00), .aux_tick_in(4'h0),
        .aux2_cap_in(4'h0), .rtc_cap_in(rtc_cap_in),
        .rtc_time(rtc_time), .rat_time(rat_time),
        .gpt_out(gpt_out), .gpt_tmo(gpt_tmo), .aux_evt(aux_evt),
        .aux2_evt(aux2_evt), .aux2_pwm(aux2_pwm),
        .wdt_irq(wdt_irq), .wdt_rst(wdt_rst)
    );

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    // one bus transfer, held until ready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) chk("bus ready", 32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits for the selected event output, c holds the cycles taken
    task wt(input int s, input int lim);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (sel[s] !== 1'b1 && c < lim);
        if (c >= lim) chk("event wait", 32'h1, 32'h0);
    endtask

    // slow clock ticks, kept well above the input pulse minimum
    task lf_tick(input int k, input int w);
        repeat (k) begin
            lf <= 1'b1;
            repeat (4) @(posedge pclk);
            lf <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        rm += k * w;
    endtask

    task stop_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        chk("run time", 32'h1, 32'h0);
        stop_test();
    end

    initial begin
        void'($urandom(82457));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset value", rv[i], rd);
        end
        apb(1'b0, 12'h200, 32'h0);
        chk("unmapped error", 32'h1, 32'(er));
        // slow counter: rate, adjust, power and debug behaviour
        rm = 0;
        lf_tick(5, 2);
        chk("rtc count", rm, rtc_time);
        n = $urandom_range(1, 4);
        apb(1'b1, 12'h004, n << 16);
        lf_tick(3, n);
        chk("rtc adjusted", rm, rtc_time);
        pwr_mode <= 2'h2;
        repeat (4) @(posedge pclk);
        lf_tick(2, n);
        chk("rtc standby", rm, rtc_time);
        pwr_mode <= 2'h3;
        repeat (4) @(posedge pclk);
        lf_tick(2, 0);
        chk("rtc shutdown", rm, rtc_time);
        pwr_mode <= 2'h0;
        dbg_halt <= 1'b1;
        repeat (4) @(posedge pclk);
        lf_tick(2, 0);
        chk("rtc debug", rm, rtc_time);
        dbg_halt <= 1'b0;
        rtc_cap_in <= 3'h7;
        repeat (6) @(posedge pclk);
        rtc_cap_in <= 3'h0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'h020 + 12'(4 * i), 32'h0);
            chk("rtc capture", rm, rd);
        end
        // radio counter picks up slow time, 4e6 per second
        m = int'((64'(rm) * 64'd4000000) >> 16);
        radio_on <= 1'b1;
        repeat (6) @(posedge pclk);
        v = rat_time;
        chk("rat resync", 32'h1, 32'(v >= m && v <= m + 2));
        repeat (100) @(posedge pclk);
        v = rat_time - v;
        chk("rat rate", 32'h1, 32'(v >= 9 && v <= 11));
        apb(1'b0, 12'h104, 32'h0);
        chk("rat status", 32'h3, rd);
        radio_on <= 1'b0;
        // general timer half 0: periodic, pwm, deep mode, oneshot
        n = $urandom_range(8, 40);
        m = n / 2;
        apb(1'b1, 12'h044, n);
        apb(1'b1, 12'h040, 32'h3);
        wt(0, 200);
        wt(0, 200);
        chk("gpt period", n + 1, c);
        apb(1'b1, 12'h048, m);
        apb(1'b1, 12'h040, 32'h5);
        repeat (n + 1) @(posedge pclk);
        v = 0;
        repeat (2 * (n + 1)) begin
            @(posedge pclk);
            v += int'(gpt_out[0] === 1'b1);
        end
        chk("pwm high time", 2 * (m + 1), v);
        pwr_mode <= 2'h2;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h04C, 32'h0);
        v = rd;
        repeat (40) @(posedge pclk);
        apb(1'b0, 12'h04C, 32'h0);
        chk("gpt frozen", v, rd);
        pwr_mode <= 2'h0;
        apb(1'b1, 12'h040, 32'h1);
        wt(0, 200);
        apb(1'b0, 12'h040, 32'h0);
        chk("oneshot stop", 32'h0, rd & 32'h1);
        // aux timer 0 with 2^N prescale
        n = $urandom_range(1, 3);
        m = $urandom_range(3, 10);
        apb(1'b1, 12'h0C4, m);
        apb(1'b1, 12'h0C0, 32'h1 | (n << 5));
        wt(1, 500);
        wt(1, 500);
        chk("aux period", (m + 1) << n, c);
        // watchdog: sticky enable, freeze, interrupt then reset
        apb(1'b1, 12'h110, 32'hF);
        apb(1'b1, 12'h118, 32'h0);
        apb(1'b1, 12'h114, 32'h1);
        apb(1'b1, 12'h114, 32'h0);
        apb(1'b0, 12'h114, 32'h0);
        chk("wdt sticky", 32'h1, rd & 32'h1);
        dbg_halt <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h11C, 32'h0);
        v = rd;
        repeat (100) @(posedge pclk);
        apb(1'b0, 12'h11C, 32'h0);
        chk("wdt frozen", v, rd);
        dbg_halt <= 1'b0;
        wt(2, 1000);
        wt(3, 1000);
        chk("wdt second", 32'h1, 32'(c >= 396 && c <= 456));
        wt(2, 1000);
        apb(1'b1, 12'h118, 32'h0);
        repeat (2) @(posedge pclk);
        chk("wdt service", 32'h0, 32'(wdt_irq));
        stop_test();
    end
endmodule

bind timer_subsystem timer_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt),
    .pwr_mode(pwr_mode), .radio_on(radio_on), .gpt_tmo(gpt_tmo),
    .rtc_time(rtc_time), .rat_time(rat_time), .wdt_irq(wdt_irq),
    .wdt_rst(wdt_rst)
);
